// File: hdl/ifeb_pkg.sv
package ifeb_pkg;

    // register word and bus geometry
    localparam int unsigned REG_W = 16;
    localparam int unsigned ADR_W = 8;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned IRQ_W = 2;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_FLAG3 = 8'h00;
    localparam logic [7:0] OFS_FLAG4 = 8'h04;
    localparam logic [7:0] OFS_EN0 = 8'h08;
    localparam logic [7:0] OFS_EN1 = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

    // implemented-bit masks; all other bits read as zero and ignore writes
    localparam logic [15:0] FLAG3_MASK = 16'h39FF;
    localparam logic [15:0] FLAG4_MASK = 16'h00F6;
    localparam logic [15:0] EN0_MASK = 16'h7FFF;
    localparam logic [15:0] EN1_MASK = 16'hFFFB;

    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RST_DAT = 32'h0000_0000;
    localparam logic [1:0] RST_IRQ = 2'h0;

    // status bits of the summary interrupt register
    localparam int unsigned IRQ_FLAG3_BIT = 0;
    localparam int unsigned IRQ_FLAG4_BIT = 1;

    // bus slave states
    typedef enum logic [1:0] {
        IFEB_ST_IDLE = 2'b01,
        IFEB_ST_ACK = 2'b10
    } ifeb_bus_e;

    // third flag register layout, msb first
    typedef struct packed {
        logic [1:0] rsv_15_14;
        logic dma_ch5_done_flag;
        logic codec_if_event_flag;
        logic codec_if_error_flag;
        logic [1:0] rsv_10_9;
        logic can2_event_flag;
        logic can2_rx_ready_flag;
        logic ext_irq4_flag;
        logic ext_irq3_flag;
        logic timer9_flag;
        logic timer8_flag;
        logic i2c2_master_flag;
        logic i2c2_slave_flag;
        logic timer7_flag;
    } ifeb_flag3_s;

    // fourth flag register layout, msb first
    typedef struct packed {
        logic [7:0] rsv_15_8;
        logic can2_tx_request_flag;
        logic can1_tx_request_flag;
        logic dma_ch7_done_flag;
        logic dma_ch6_done_flag;
        logic rsv_3;
        logic uart2_error_flag;
        logic uart1_error_flag;
        logic rsv_0;
    } ifeb_flag4_s;

    // all state of the top module
    typedef struct packed {
        ifeb_bus_e st;
        logic ack;
        logic [31:0] rdat;
        logic [15:0] en0;
        logic [15:0] en1;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [15:0] pend0;
        logic [15:0] pend1;
        logic [15:0] pend3;
        logic [15:0] pend4;
        logic irq;
    } ifeb_state_s;

endpackage : ifeb_pkg

// File: hdl/ifeb_flag_bank.sv
`timescale 1ns/1ns
`default_nettype none
module ifeb_flag_bank #(
    parameter int unsigned W = 16,
    parameter logic [W-1:0] MASK = '1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // hardware request pulses or levels
    input wire logic [W-1:0] evt_i,
    // software write
    input wire logic wr_i,
    input wire logic [W-1:0] wr_be_i,
    input wire logic [W-1:0] wr_data_i,
    // flag state
    output logic [W-1:0] flags_o,
    output logic set_o
);

    typedef struct packed {
        logic [W-1:0] flags;
    } ifeb_bank_s;

    ifeb_bank_s s_q;
    ifeb_bank_s s_d;
    logic [W-1:0] nxt;

    // per bit: a request sets the flag and wins over a software write of zero
    for (genvar b = 0; b < W; b++) begin : g_bit
        if (MASK[b]) begin : g_impl
            assign nxt[b] = evt_i[b] ? 1'b1 : ((wr_i && wr_be_i[b]) ? wr_data_i[b] : s_q.flags[b]);
        end else begin : g_rsv
            assign nxt[b] = 1'b0;
        end
    end

    // next state
    always_comb begin
        s_d = s_q;
        s_d.flags = nxt;
        if (rst_i) begin
            s_d.flags = '0;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    assign flags_o = s_q.flags;
    assign set_o = |(evt_i & MASK);

endmodule : ifeb_flag_bank
`default_nettype wire

// File: hdl/ifeb_top.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Third flag register bits 13, 12, 11 and 8 latch DMA channel 5 done, codec event, codec error and CAN2 event.
// - Third flag register bits 15-14 and 10-9 always read zero and ignore writes.
// - Third flag register bits 7..3 latch CAN2 receive-ready, external irq 4 and 3, timer 9 and timer 8.
// - Third flag register bits 2, 1, 0 latch I2C2 master, I2C2 slave and timer 7 requests.
// - Fourth flag register bits 7, 6, 5, 4, 2, 1 latch CAN2/CAN1 transmit, DMA 7/6 done, UART2/UART1 error.
// - Fourth flag register bits 15-8, 3 and 0 always read zero.
// - A flag reads one once its source has requested and zero otherwise, and software can read and write it.
// - An enable bit of one lets its source's request through and zero blocks it.
// - First enable register bits 14..8 are DMA 1, ADC1, UART1 tx, UART1 rx, SPI1 event, SPI1 error, timer 3; bit 15 reads zero.
// - First enable register bits 7..0 are timer 2, compare 2, capture 2, DMA 0, timer 1, compare 1, capture 1, ext irq 0.
// - Second enable register bits 15..8 are UART2 tx, UART2 rx, ext irq 2, timer 5, timer 4, compare 4, compare 3, DMA 2.
// - Second enable register low byte holds capture 8, capture 7, ADC2, ext irq 1, pin change, I2C1 master, I2C1 slave; bit 2 is absent.
// - Bit 0 of the second enable register passes the I2C1 slave request when one and blocks it when zero.
module ifeb_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // request sources for the third and fourth flag registers
    input wire ifeb_pkg::ifeb_flag3_s flag3_evt_i,
    input wire ifeb_pkg::ifeb_flag4_s flag4_evt_i,
    // flags and enables held outside this bank
    input wire logic [15:0] flag0_i,
    input wire logic [15:0] flag1_i,
    input wire logic [15:0] en3_i,
    input wire logic [15:0] en4_i,
    // requests toward arbitration, flag and enable both set
    output logic [15:0] pend0_o,
    output logic [15:0] pend1_o,
    output logic [15:0] pend3_o,
    output logic [15:0] pend4_o,
    // enable registers for the first two flag banks
    output logic [15:0] en0_o,
    output logic [15:0] en1_o,
    // summary interrupt
    output logic irq_o
);

    ifeb_pkg::ifeb_state_s s_q;
    ifeb_pkg::ifeb_state_s s_d;
    logic [15:0] flag3;
    logic [15:0] flag4;
    logic set3;
    logic set4;
    logic req;
    logic fire;
    logic [15:0] be16;
    logic [15:0] wdat16;
    logic wr_flag3;
    logic wr_flag4;

    // bus request decode; a write lands on the edge where the master sees ack
    assign req = wb_cyc_i && wb_stb_i;
    assign fire = req && wb_we_i && (s_q.st == ifeb_pkg::IFEB_ST_ACK);
    assign be16 = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdat16 = wb_dat_i[15:0];
    assign wr_flag3 = fire && (wb_adr_i == ifeb_pkg::OFS_FLAG3);
    assign wr_flag4 = fire && (wb_adr_i == ifeb_pkg::OFS_FLAG4);

    // third flag register
    ifeb_flag_bank #(
        .W(ifeb_pkg::REG_W),
        .MASK(ifeb_pkg::FLAG3_MASK)
    ) u_flag3 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .evt_i(flag3_evt_i),
        .wr_i(wr_flag3),
        .wr_be_i(be16),
        .wr_data_i(wdat16),
        .flags_o(flag3),
        .set_o(set3)
    );

    // fourth flag register
    ifeb_flag_bank #(
        .W(ifeb_pkg::REG_W),
        .MASK(ifeb_pkg::FLAG4_MASK)
    ) u_flag4 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .evt_i(flag4_evt_i),
        .wr_i(wr_flag4),
        .wr_be_i(be16),
        .wr_data_i(wdat16),
        .flags_o(flag4),
        .set_o(set4)
    );

    // next state: bus slave, enables, summary interrupt, gated requests
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        case (s_q.st)
            ifeb_pkg::IFEB_ST_IDLE: begin
                if (req) begin
                    s_d.st = ifeb_pkg::IFEB_ST_ACK;
                    s_d.ack = 1'b1;
                    case (wb_adr_i)
                        ifeb_pkg::OFS_FLAG3: s_d.rdat = {16'h0000, flag3};
                        ifeb_pkg::OFS_FLAG4: s_d.rdat = {16'h0000, flag4};
                        ifeb_pkg::OFS_EN0: s_d.rdat = {16'h0000, s_q.en0};
                        ifeb_pkg::OFS_EN1: s_d.rdat = {16'h0000, s_q.en1};
                        ifeb_pkg::OFS_IRQ_STAT: s_d.rdat = {30'h0000_0000, s_q.stat};
                        ifeb_pkg::OFS_IRQ_MASK: s_d.rdat = {30'h0000_0000, s_q.mask};
                        default: s_d.rdat = ifeb_pkg::RST_DAT;
                    endcase
                end
            end
            ifeb_pkg::IFEB_ST_ACK: begin
                s_d.st = ifeb_pkg::IFEB_ST_IDLE;
            end
            default: begin
                s_d.st = ifeb_pkg::IFEB_ST_IDLE;
            end
        endcase
        // enable register writes, absent bits forced to zero
        if (fire && wb_adr_i == ifeb_pkg::OFS_EN0) begin
            s_d.en0 = ((s_q.en0 & ~be16) | (wdat16 & be16)) & ifeb_pkg::EN0_MASK;
        end
        if (fire && wb_adr_i == ifeb_pkg::OFS_EN1) begin
            s_d.en1 = ((s_q.en1 & ~be16) | (wdat16 & be16)) & ifeb_pkg::EN1_MASK;
        end
        if (fire && wb_adr_i == ifeb_pkg::OFS_IRQ_MASK && wb_sel_i[0]) begin
            s_d.mask = wb_dat_i[1:0];
        end
        // sticky status: write one clears, a new set in the same cycle wins
        if (fire && wb_adr_i == ifeb_pkg::OFS_IRQ_STAT && wb_sel_i[0]) begin
            s_d.stat = s_q.stat & ~wb_dat_i[1:0];
        end
        s_d.stat[ifeb_pkg::IRQ_FLAG3_BIT] = s_d.stat[ifeb_pkg::IRQ_FLAG3_BIT] | set3;
        s_d.stat[ifeb_pkg::IRQ_FLAG4_BIT] = s_d.stat[ifeb_pkg::IRQ_FLAG4_BIT] | set4;
        s_d.irq = |(s_q.stat & s_q.mask);
        // requests pass only where flag and enable are both set
        s_d.pend0 = flag0_i & s_q.en0;
        s_d.pend1 = flag1_i & s_q.en1;
        s_d.pend3 = flag3 & en3_i;
        s_d.pend4 = flag4 & en4_i;
        if (rst_i) begin
            s_d.st = ifeb_pkg::IFEB_ST_IDLE;
            s_d.ack = 1'b0;
            s_d.rdat = ifeb_pkg::RST_DAT;
            s_d.en0 = ifeb_pkg::RST_WORD;
            s_d.en1 = ifeb_pkg::RST_WORD;
            s_d.stat = ifeb_pkg::RST_IRQ;
            s_d.mask = ifeb_pkg::RST_IRQ;
            s_d.pend0 = ifeb_pkg::RST_WORD;
            s_d.pend1 = ifeb_pkg::RST_WORD;
            s_d.pend3 = ifeb_pkg::RST_WORD;
            s_d.pend4 = ifeb_pkg::RST_WORD;
            s_d.irq = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    // outputs straight from flip-flops
    assign wb_dat_o = s_q.rdat;
    assign wb_ack_o = s_q.ack;
    assign pend0_o = s_q.pend0;
    assign pend1_o = s_q.pend1;
    assign pend3_o = s_q.pend3;
    assign pend4_o = s_q.pend4;
    assign en0_o = s_q.en0;
    assign en1_o = s_q.en1;
    assign irq_o = s_q.irq;

    // checks on the bank's own behaviour
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence seq_wr_full(logic [7:0] ofs);
        req && wb_we_i && wb_adr_i == ofs && wb_sel_i[1:0] == 2'h3 && !wb_ack_o ##1 wb_ack_o;
    endsequence

    sequence seq_rd(logic [7:0] ofs);
        req && !wb_we_i && wb_adr_i == ofs && !wb_ack_o;
    endsequence

    flag3_rsv_zero_a: assert property (flag3[15:14] == 2'h0 && flag3[10:9] == 2'h0)
        else $error("third flag register reserved bit set");

    flag4_rsv_zero_a: assert property ((flag4 & ~ifeb_pkg::FLAG4_MASK) == 16'h0000)
        else $error("fourth flag register reserved bit set");

    flag3_high_set_a: assert property (flag3_evt_i.dma_ch5_done_flag |=> flag3[13] ##1 flag3[13] || $past(wr_flag3))
        else $error("dma channel 5 request not latched");

    flag3_low_set_a: assert property ((flag3_evt_i[7:3] != 5'h00) |=> ((flag3[7:3] & $past(flag3_evt_i[7:3])) == $past(flag3_evt_i[7:3])))
        else $error("third flag low byte request lost");

    flag3_bits_set_a: assert property ((flag3_evt_i[2:0] != 3'h0) |=> ((flag3[2:0] & $past(flag3_evt_i[2:0])) == $past(flag3_evt_i[2:0])))
        else $error("third flag i2c or timer request lost");

    flag4_set_a: assert property ((flag4_evt_i & ifeb_pkg::FLAG4_MASK) != 16'h0000 |=> ((flag4 & $past(flag4_evt_i & ifeb_pkg::FLAG4_MASK)) == $past(flag4_evt_i & ifeb_pkg::FLAG4_MASK)))
        else $error("fourth flag request lost");

    flag_sw_write_a: assert property (seq_wr_full(ifeb_pkg::OFS_FLAG3) ##0 (flag3_evt_i == '0) |=> flag3 == ($past(wdat16) & ifeb_pkg::FLAG3_MASK))
        else $error("software write to flag register not taken");

    reset_clear_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> (en0_o == 16'h0000 && en1_o == 16'h0000 && (flag3 | flag4) == 16'h0000))
        else $error("register not zero after reset");

    en0_write_a: assert property (seq_wr_full(ifeb_pkg::OFS_EN0) |=> en0_o == ($past(wdat16) & ifeb_pkg::EN0_MASK))
        else $error("first enable register write wrong");

    en1_write_a: assert property (seq_wr_full(ifeb_pkg::OFS_EN1) |=> en1_o == ($past(wdat16) & ifeb_pkg::EN1_MASK))
        else $error("second enable register write wrong");

    pend_gate_a: assert property (##1 pend1_o == ($past(flag1_i) & $past(en1_o)) && pend0_o == ($past(flag0_i) & $past(en0_o)))
        else $error("pending request not gated by enable");

    pend3_gate_a: assert property (##1 pend3_o == ($past(flag3) & $past(en3_i)))
        else $error("third bank pending wrong");

    rd_flag_ack_a: assert property (seq_rd(ifeb_pkg::OFS_FLAG3) |=> wb_ack_o && wb_dat_o == {16'h0000, $past(flag3)} ##1 !wb_ack_o)
        else $error("flag read answer wrong");

    irq_level_a: assert property (##1 irq_o == |($past(s_q.stat) & $past(s_q.mask)))
        else $error("summary interrupt does not follow status and mask");

endmodule : ifeb_top
`default_nettype wire

// File: test/ifeb_src_model.sv
`timescale 1ns/1ns
`default_nettype none
// stand-in for the peripheral sources and the flags and enables held elsewhere
module ifeb_src_model (
    // clock
    input wire logic clk_i,
    // request lines toward the flag registers
    output var ifeb_pkg::ifeb_flag3_s evt3_o,
    output var ifeb_pkg::ifeb_flag4_s evt4_o,
    // flags and enables kept outside the bank
    output var logic [15:0] flag0_o,
    output var logic [15:0] flag1_o,
    output var logic [15:0] en3_o,
    output var logic [15:0] en4_o
);
    // sources stay quiet until told otherwise
    initial begin
        evt3_o = '0;
        evt4_o = '0;
        flag0_o = 16'h0000;
        flag1_o = 16'h0000;
        en3_o = 16'h0000;
        en4_o = 16'h0000;
    end
    // one-cycle request raised just after an edge
    task pulse(input logic [15:0] e3, input logic [15:0] e4);
        @(posedge clk_i);
        evt3_o <= e3;
        evt4_o <= e4;
        @(posedge clk_i);
        evt3_o <= '0;
        evt4_o <= '0;
    endtask : pulse
    // held levels of the outside flags and enables
    task levels(input logic [15:0] f0, input logic [15:0] f1, input logic [15:0] e3,
                input logic [15:0] e4);
        @(posedge clk_i);
        flag0_o <= f0;
        flag1_o <= f1;
        en3_o <= e3;
        en4_o <= e4;
    endtask : levels
endmodule : ifeb_src_model
`default_nettype wire

// File: test/tb_interrupt_flag_enable_bank.sv
`timescale 1ns/1ns
`default_nettype none
module tb_interrupt_flag_enable_bank;
    // bench signals
    logic clk_i, rst_i, cyc, stb, we, ack, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, rd_data;
    ifeb_pkg::ifeb_flag3_s evt3;
    ifeb_pkg::ifeb_flag4_s evt4;
    logic [15:0] f0, f1, e3, e4, p0, p1, p3, p4, en0, en1;
    logic [7:0] ofs [4];
    logic [15:0] msk [4];
    int fails, num_checks;
    // design and far side
    ifeb_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .flag3_evt_i(evt3), .flag4_evt_i(evt4), .flag0_i(f0),
        .flag1_i(f1), .en3_i(e3), .en4_i(e4), .pend0_o(p0), .pend1_o(p1), .pend3_o(p3),
        .pend4_o(p4), .en0_o(en0), .en1_o(en1), .irq_o(irq));
    ifeb_src_model src (.clk_i(clk_i), .evt3_o(evt3), .evt4_o(evt4), .flag0_o(f0),
        .flag1_o(f1), .en3_o(e3), .en4_o(e4));
    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // verdict and end of run
    task results();
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    // compare one value
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one classic cycle, held until ack is sampled high
    task bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd_data = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            fails++;
            results();
        end
    endtask : bus
    // read and compare
    task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 4'hF, 32'h0000_0000);
        check(what, rd_data, exp);
    endtask : rchk
    // main sequence
    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0000_0000;
        fails = 0;
        num_checks = 0;
        ofs = '{ifeb_pkg::OFS_FLAG3, ifeb_pkg::OFS_FLAG4, ifeb_pkg::OFS_EN0, ifeb_pkg::OFS_EN1};
        msk = '{ifeb_pkg::FLAG3_MASK, ifeb_pkg::FLAG4_MASK, ifeb_pkg::EN0_MASK,
                ifeb_pkg::EN1_MASK};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        // everything clear after reset, unmapped place reads zero
        for (int i = 0; i < 4; i++) begin
            rchk("reset word", ofs[i], 32'h0000_0000);
        end
        rchk("status", ifeb_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        rchk("unmapped", 8'h20, 32'h0000_0000);
        check("irq after reset", irq, 1'b0);
        // all ones written, only implemented bits stick
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, ofs[i], 4'hF, 32'hFFFF_FFFF);
            rchk("implemented bits", ofs[i], {16'h0000, msk[i]});
        end
        check("enable zero out", en0, ifeb_pkg::EN0_MASK);
        check("enable one out", en1, ifeb_pkg::EN1_MASK);
        // software clears flags with zeros, low lane alone sets the low byte
        bus(1'b1, ifeb_pkg::OFS_FLAG3, 4'hF, 32'h0000_0000);
        bus(1'b1, ifeb_pkg::OFS_FLAG4, 4'hF, 32'h0000_0000);
        rchk("cleared", ifeb_pkg::OFS_FLAG4, 32'h0000_0000);
        bus(1'b1, ifeb_pkg::OFS_FLAG3, 4'h1, 32'h0000_FFFF);
        rchk("low lane", ifeb_pkg::OFS_FLAG3, 32'h0000_00FF);
        bus(1'b1, ifeb_pkg::OFS_FLAG3, 4'hF, 32'h0000_0000);
        // each source line sets its own bit only
        for (int i = 0; i < 16; i++) begin
            src.pulse(16'h0001 << i, 16'h0001 << i);
            rchk("flag three bit", ifeb_pkg::OFS_FLAG3, {16'h0000, ifeb_pkg::FLAG3_MASK & (16'h0001 << i)});
            rchk("flag four bit", ifeb_pkg::OFS_FLAG4, {16'h0000, ifeb_pkg::FLAG4_MASK & (16'h0001 << i)});
            bus(1'b1, ifeb_pkg::OFS_FLAG3, 4'hF, 32'h0000_0000);
            bus(1'b1, ifeb_pkg::OFS_FLAG4, 4'hF, 32'h0000_0000);
        end
        bus(1'b1, ifeb_pkg::OFS_IRQ_STAT, 4'hF, 32'h0000_0003);
        // flag sets while disabled, request shows only once enabled
        src.levels(16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000);
        src.pulse(16'h0001, 16'h0000);
        repeat (3) @(posedge clk_i);
        check("pend three off", p3, 16'h0000);
        rchk("flag while off", ifeb_pkg::OFS_FLAG3, 32'h0000_0001);
        src.levels(16'hFFFF, 16'hFFFF, 16'h0001, 16'h0000);
        repeat (3) @(posedge clk_i);
        check("pend three on", p3, 16'h0001);
        // fourth bank: uart2 error flag passes with its outside enable set; then first and second enable gating
        src.pulse(16'h0000, 16'h0004);
        src.levels(16'hFFFF, 16'hFFFF, 16'h0001, 16'h0006);
        repeat (3) @(posedge clk_i);
        check("pend four on", p4, 16'h0004);
        check("pend zero", p0, ifeb_pkg::EN0_MASK);
        bus(1'b1, ifeb_pkg::OFS_EN1, 4'hF, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        check("slave enable on", p1, 16'h0001);
        bus(1'b1, ifeb_pkg::OFS_EN1, 4'hF, 32'h0000_0000);
        repeat (3) @(posedge clk_i);
        check("slave enable off", p1, 16'h0000);
        // summary interrupt: masked, unmasked, cleared
        check("irq masked", irq, 1'b0);
        bus(1'b1, ifeb_pkg::OFS_IRQ_MASK, 4'hF, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        check("irq unmasked", irq, 1'b1);
        bus(1'b1, ifeb_pkg::OFS_IRQ_STAT, 4'hF, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        check("irq cleared", irq, 1'b0);
        results();
    end
endmodule : tb_interrupt_flag_enable_bank
`default_nettype wire
